// ==== verilog/ssp_regs.vh ====
// ssp_regs.vh: constants for the synchronous serial port pin engine
// assumes inclusion by ssp_top.v and ssp_sync.v only
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_CNT_W        8
`define SSP_DIV_DEF      8'h0004
`define SSP_BITS_W       4
`define SSP_LAST_BIT     4'h7
`define SSP_ST_IDLE      2'h0
`define SSP_ST_LEAD      2'h1
`define SSP_ST_TRAIL     2'h2
`define SSP_ST_DONE      2'h3
`endif

// ==== verilog/ssp_sync.v ====
// ssp_sync.v: three-stage input synchroniser for pin inputs
// assumes an asynchronous input and one ref_clk domain
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_sync (
    // clock and reset
    input  wire ref_clk,
    input  wire sys_rst,
    // pin side
    input  wire pin_in,
    // filtered level
    output reg  level_out
);
    reg s1_r;   // first stage, read only by s2
    reg s2_r;   // second stage
    reg s3_r;   // third stage

    // shift chain; level changes once stages two and three agree
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// ==== verilog/ssp_top.v ====
// ssp_top.v: synchronous serial port master, pin-level engine
// assumes a 20 MHz ref_clk and a peripheral honouring the clock edges
// Summary of operation
// - clock toggles only during a transaction, held at the idle level otherwise
// - idle clock level is selectable
// - launch edge selectable, sample on other
// - capture input on edge opposite launch
// - data output released when not transmitting
// - shared wire: receive while output released
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_top (
    // clock and reset
    input  wire       ref_clk,
    input  wire       sys_rst,
    // configuration
    input  wire       cfg_idle_high,
    input  wire       cfg_launch_trail,
    input  wire [7:0] cfg_half_div,
    // user command side
    input  wire       start,
    input  wire       xmit,
    input  wire [7:0] tx_byte,
    output wire       busy,
    output reg        done_r,
    output reg  [7:0] rx_byte_r,
    // pins
    output reg        serial_clock_out,
    output reg        serial_data_out,
    output reg        serial_data_oe,
    input  wire       serial_data_in
);
    // ------------------------------------------------------------------
    // state and datapath registers
    // ------------------------------------------------------------------
    reg  [1:0]                state_r;    // sequencer state
    reg  [`SSP_CNT_W-1:0]     cnt_r;      // half period counter
    reg  [`SSP_BITS_W-1:0]    bit_r;      // bit index
    reg  [7:0]                sh_r;       // transmit shift, msb next out
    reg  [7:0]                rx_r;       // receive shift, lsb newest
    reg                       xmit_r;     // transaction is a transmit
    wire                      din_s;      // synchronised input
    wire                      tick;       // half period enable
    wire [`SSP_CNT_W-1:0]     div_use;    // divider, never zero
    wire                      last_bit;   // current bit is the final one

    // ------------------------------------------------------------------
    // edge role decode
    // ------------------------------------------------------------------
    // true when the edge about to be made launches data; the other edge
    // of the same bit then samples, so launch and sample never coincide
    // lead_edge: the edge leaves the idle level
    // launch_trail: data moves on the edge that returns to idle
    function ssp_edge_launches;
        input lead_edge;
        input launch_trail;
        begin
            ssp_edge_launches = lead_edge ^ launch_trail;
        end
    endfunction

    // ------------------------------------------------------------------
    // divider and status
    // ------------------------------------------------------------------
    // a zero divider would make the half period counter tick every cycle, so use default
    assign div_use  = (cfg_half_div == 8'h00) ? `SSP_DIV_DEF : cfg_half_div;
    // one-cycle enable at the end of every half period
    assign tick     = (cnt_r == 8'h00);
    // busy from the edge after start until the release cycle
    assign busy     = (state_r != `SSP_ST_IDLE);
    // final bit of the byte: no launch may follow its sample
    assign last_bit = (bit_r == `SSP_LAST_BIT);

    // pin input synchroniser
    ssp_sync u_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .pin_in    (serial_data_in),
        .level_out (din_s)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // each bit is a lead half then a trail half; every half ends on tick
    // with one clock edge. which edge launches and which samples is set
    // by cfg_launch_trail:
    //   launch on lead: first bit leaves on edge one, sample on trail
    //   launch on trail: first bit set up before edge one, sample on lead
    // the input path is four flops deep, so the divider must give the
    // peripheral's bit at least four cycles before the sampling edge
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r          <= `SSP_ST_IDLE;
            cnt_r            <= 8'h00;
            bit_r            <= 4'h0;
            sh_r             <= 8'h00;
            rx_r             <= 8'h00;
            xmit_r           <= 1'b0;
            done_r           <= 1'b0;
            rx_byte_r        <= 8'h00;
            serial_clock_out <= 1'b0;
            serial_data_out  <= 1'b1;
            serial_data_oe   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            cnt_r  <= tick ? div_use : cnt_r - 8'h01;
            case (state_r)
                `SSP_ST_IDLE: begin
                    serial_clock_out <= cfg_idle_high;
                    serial_data_oe   <= 1'b0;
                    if (start) begin
                        // frame accepted; start is ignored while busy
                        state_r <= `SSP_ST_LEAD;
                        cnt_r   <= div_use;
                        bit_r   <= 4'h0;
                        xmit_r  <= xmit;
                        serial_data_oe <= xmit;
                        if (cfg_launch_trail) begin
                            // trail launch: first bit must stand before edge one
                            serial_data_out <= tx_byte[7];
                            sh_r            <= {tx_byte[6:0], 1'b0};
                        end else begin
                            // lead launch: line stays high until edge one
                            serial_data_out <= 1'b1;
                            sh_r            <= tx_byte;
                        end
                    end
                end
                `SSP_ST_LEAD: begin
                    if (tick) begin
                        // first edge of the bit leaves the idle level
                        serial_clock_out <= ~serial_clock_out;
                        if (ssp_edge_launches(1'b1, cfg_launch_trail)) begin
                            // launch edge: next bit onto the line
                            serial_data_out <= sh_r[7];
                            sh_r            <= {sh_r[6:0], 1'b0};
                        end else begin
                            // sample edge: peripheral bit is settled
                            rx_r <= {rx_r[6:0], din_s};
                        end
                        state_r <= `SSP_ST_TRAIL;
                    end
                end
                `SSP_ST_TRAIL: begin
                    if (tick) begin
                        // second edge returns clock to idle
                        serial_clock_out <= ~serial_clock_out;
                        if (ssp_edge_launches(1'b0, cfg_launch_trail)) begin
                            // launch edge, but never a ninth bit
                            if (!last_bit) begin
                                serial_data_out <= sh_r[7];
                                sh_r            <= {sh_r[6:0], 1'b0};
                            end
                        end else begin
                            // sample edge for lead launch mode
                            rx_r <= {rx_r[6:0], din_s};
                        end
                        if (last_bit) begin
                            state_r <= `SSP_ST_DONE;
                        end else begin
                            bit_r   <= bit_r + 4'h1;
                            state_r <= `SSP_ST_LEAD;
                        end
                    end
                end
                default: begin
                    // one half period hold of the last bit, then release
                    // the line and hand over the received byte
                    if (tick) begin
                        serial_data_oe  <= 1'b0;
                        serial_data_out <= 1'b1;
                        rx_byte_r       <= rx_r;
                        done_r          <= 1'b1;
                        state_r         <= `SSP_ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ==== dv/ssp_top_sva.sv ====
// ssp_top_sva.sv: pin rule checker for ssp_top
// assumes bind onto ssp_top, one ref_clk domain
`timescale 1ns/1ps
module ssp_chk (
    input wire       ref_clk, sys_rst, cfg_idle_high, xmit, busy, done_r,
    input wire       serial_clock_out, serial_data_out, serial_data_oe,
    input wire [7:0] rx_byte_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    clk_idle_a: assert property (!busy && !$past(sys_rst)
        |-> serial_clock_out == cfg_idle_high) else $error("clock off idle level");
    clk_quiet_a: assert property ($changed(serial_clock_out)
        |-> busy || $past(busy) || $past(sys_rst, 2)) else $error("clock moved outside frame");
    out_float_a: assert property (!busy |-> !serial_data_oe) else $error("driven when idle");
    oe_dir_a: assert property ($rose(busy) |-> serial_data_oe == $past(xmit))
        else $error("drive enable not per direction");
    launch_a: assert property (serial_data_oe && $past(busy) && $changed(serial_data_out)
        |-> $changed(serial_clock_out)) else $error("data moved off a clock edge");
    done_once_a: assert property (done_r |=> !done_r) else $error("done longer than a cycle");
    cover property ($rose(busy) && xmit);
    cover property ($rose(busy) && !xmit);
    cover property (done_r && cfg_idle_high);
    cover property (done_r && !cfg_idle_high);
endmodule
bind ssp_top ssp_chk i_chk (.*);

// ==== dv/ssp_periph.sv ====
// ssp_periph.sv: three-pin serial peripheral on the shared data wire
// assumes the device clock and a pulled-up open-drain wire
`timescale 1ns/1ps
module ssp_periph (
    input wire            serial_clock_out, cfg_idle_high, cfg_launch_trail,
    input wire            serial_data_in, load, xmit,
    input wire [7:0]      tx_byte,
    output reg [7:0]      seen_byte = 8'h00,
    output wire           pull_low
);
    reg [7:0] sh_r = 8'hFF; // bits still to return, msb next
    reg out_r = 1'b1;       // bit now on the wire, 1 = released
    // launch on the device's launch edge, capture on its other edge
    always @(posedge load or posedge serial_clock_out or negedge serial_clock_out) begin
        if (load) begin
            out_r <= cfg_launch_trail ? tx_byte[7] : 1'b1;
            sh_r  <= cfg_launch_trail ? {tx_byte[6:0], 1'b1} : tx_byte;
        end else if ((serial_clock_out != cfg_idle_high) != cfg_launch_trail) begin
            out_r <= sh_r[7];
            sh_r  <= {sh_r[6:0], 1'b1};
        end else
            seen_byte <= {seen_byte[6:0], serial_data_in};
    end
    // pulls low only while the device listens
    assign pull_low = !xmit && !out_r;
endmodule

// ==== dv/tb.sv ====
// tb.sv: self-checking bench for ssp_top with a peripheral model
// assumes ssp_top, ssp_periph and ssp_chk compiled first
`timescale 1ns/1ps
module tb;
    reg ref_clk = 0, sys_rst = 1, cfg_idle_high = 0, cfg_launch_trail = 0;
    reg start = 0, xmit = 0, load = 0;
    reg [7:0] tx_byte = 8'h00;
    wire [7:0] cfg_half_div = 8'h04; // 500 ns link clock, input path needs 4
    wire busy, done_r, serial_clock_out, serial_data_out, serial_data_oe, pull_low;
    wire [7:0] rx_byte_r, seen_byte;
    wire serial_data_in = !(serial_data_oe && !serial_data_out) && !pull_low; // pulled up
    integer errors = 0, checks = 0, cyc = 0, i, n;
    reg [10:0] rows [0:4]; // idle level, launch mode, transmit, byte
    always #25 ref_clk = ~ref_clk;
    ssp_top i_dut (.*);
    ssp_periph i_per (.*);
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            final_report;
        end
    end
    // one frame; start held long so repeats mid-frame are refused
    task run(input [10:0] r);
        begin
            sys_rst = 1;
            {cfg_idle_high, cfg_launch_trail, xmit, tx_byte} = r;
            load = 1;
            repeat (2) @(posedge ref_clk);
            #1 sys_rst = 0;
            repeat (2) @(posedge ref_clk);
            #1 start = 1;
            load = 0;
            repeat (20) @(posedge ref_clk);
            #1 start = 0;
            n = 0;
            while (done_r !== 1'b1 && n < 400) begin
                @(posedge ref_clk);
                #1 n = n + 1;
            end
            if (n >= 400) errors = errors + 1;
            chk(xmit ? seen_byte : rx_byte_r, tx_byte);
            repeat (40) @(posedge ref_clk);
            #1 chk({5'h00, busy, serial_data_oe, serial_clock_out}, {7'h00, cfg_idle_high});
            $display("row %h done, errors %0d", r, errors);
        end
    endtask
    initial begin
        rows[0] = 11'h1A5;
        rows[1] = 11'h53C;
        rows[2] = 11'h296;
        rows[3] = 11'h6C3;
        rows[4] = 11'h05A;
        for (i = 0; i < 5; i = i + 1)
            run(rows[i]);
        // reset in mid-frame
        start = 1;
        repeat (30) @(posedge ref_clk);
        #1 sys_rst = 1;
        #1 chk({serial_clock_out, serial_data_oe, serial_data_out, done_r, rx_byte_r[3:0]}, 8'h20);
        cfg_idle_high = 1;
        start = 0;
        @(posedge ref_clk);
        #1 sys_rst = 0;
        @(posedge ref_clk);
        #1 chk({6'h00, busy, serial_clock_out}, 8'h01);
        $display("reset test done, errors %0d", errors);
        final_report;
    end
endmodule
